/* File: rtl/ser_cmd_decode.v */
// Command decoder: turns a register command into per-group strobes
`include "ser_consts.vh"

module ser_cmd_decode #(
	parameter NGRP = 6
) (
	// Command
	input wire cmdValid,
	input wire cmdWrite,
	input wire [2:0] cmdGroup,
	input wire [2:0] cmdReg,
	// Per-group strobes
	output wire [NGRP-1:0] wrEnable,
	output wire [NGRP-1:0] wrRise,
	output wire [NGRP-1:0] wrFall,
	output wire [NGRP-1:0] rdEvent
);
	function [NGRP-1:0] grpSel;
		input [2:0] grp;
		integer i;
		begin
			grpSel = {NGRP{1'b0}};
			for (i = 0; i < NGRP; i = i + 1) begin
				if (grp == i[2:0]) begin
					grpSel[i] = 1'b1;
				end
			end
		end
	endfunction

	wire [NGRP-1:0] sel;
	wire wr;
	wire rd;

	assign sel = cmdValid ? grpSel(cmdGroup) : {NGRP{1'b0}};
	assign wr = cmdWrite;
	assign rd = ~cmdWrite;
	assign wrEnable = (wr && cmdReg == `SER_REG_ENABLE) ? sel : {NGRP{1'b0}};
	assign wrRise = (wr && cmdReg == `SER_REG_RISE) ? sel : {NGRP{1'b0}};
	assign wrFall = (wr && cmdReg == `SER_REG_FALL) ? sel : {NGRP{1'b0}};
	// Condition and event registers take no writes
	assign rdEvent = (rd && cmdReg == `SER_REG_EVENT) ? sel : {NGRP{1'b0}};
endmodule // ser_cmd_decode

/* File: rtl/ser_consts.vh */
// Constants shared by the status event reporting block
`ifndef SER_CONSTS_VH
`define SER_CONSTS_VH

// Register word width and number of register groups
`define SER_W 16
`define SER_NGRP 6

// Group select codes on the command port
`define SER_GRP_QUES 3'h0
`define SER_GRP_OPER 3'h1
`define SER_GRP_VOLT 3'h2
`define SER_GRP_FREQ 3'h3
`define SER_GRP_SEQ 3'h4
`define SER_GRP_RUN 3'h5

// Register select codes on the command port
`define SER_REG_EVENT 3'h0
`define SER_REG_COND 3'h1
`define SER_REG_ENABLE 3'h2
`define SER_REG_FALL 3'h3
`define SER_REG_RISE 3'h4

// Implemented bit positions of each group
`define SER_MASK_QUES 16'h0421
`define SER_MASK_OPER 16'h0100
`define SER_MASK_VOLT 16'h000F
`define SER_MASK_FREQ 16'h0003
`define SER_MASK_SEQ 16'h003F
`define SER_MASK_RUN 16'h0003

// Summary bit positions inside the parent condition registers
`define SER_QUES_VOLT_BIT 0
`define SER_QUES_FREQ_BIT 5
`define SER_QUES_SEQ_BIT 10
`define SER_OPER_RUN_BIT 8

// Preset and reset values
`define SER_ENABLE_PRESET 16'h0000
`define SER_RISE_PRESET 16'hFFFF
`define SER_FALL_PRESET 16'h0000
`define SER_EVENT_CLEAR 16'h0000

`endif

/* File: rtl/ser_edge_filter.v */
// Transition filter: turns condition edges into event set requests
module ser_edge_filter #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Live conditions and filter settings
	input wire [WIDTH-1:0] cond,
	input wire [WIDTH-1:0] riseFilter,
	input wire [WIDTH-1:0] fallFilter,
	// Event set requests
	output wire [WIDTH-1:0] hit
);
	reg [WIDTH-1:0] prev_r;

	always @(posedge clk_sys) begin
		if (reset) begin
			prev_r <= {WIDTH{1'b0}};
		end else begin
			prev_r <= cond;
		end
	end

	// Both filters set catch either edge; both clear catch none
	assign hit = (cond & ~prev_r & riseFilter) | (~cond & prev_r & fallFilter);
endmodule // ser_edge_filter

/* File: rtl/ser_status_top.v */
// Status event reporting: condition, filter, event and enable groups
//
// Contract
// - Operation condition bit 8 shows that the system is running.
// - Event bits are read-only, latched until event read or clear-status.
// - Condition reads return live bits and never clear them.
// - Only enabled event bits feed the group summary bit.
// - Clear-status zeroes events and keeps enable registers.
// - Fall filter bit set: true-to-false condition change sets event bit.
// - Rise filter bit set: false-to-true condition change sets event bit.
// - Both filter bits set: any condition change sets event bit.
// - Both filter bits clear: condition changes never set event bit.
// - Transition filters survive clear-status and instrument reset commands.
// - Reads return weighted sum; enables are written as weighted sum.
// - Voltage bits 0 and 1: output 1 or 2 switched off.
// - Voltage bits 2 and 3: output 1 or 2 amplitude clipped.
// - Frequency bits 0 and 1: output 1 or 2 signal invalid.
// - Sequence bits 0 and 1: sequence table error on output 1 or 2.
// - Sequence bits 2 and 3: linear-playtime error on output 1 or 2.
// - Sequence bits 4 and 5: output 1 or 2 ran out of stream data.
// - Run bits 0 and 1: channel 1 or 2 started and generating.
// - Preset clears events, enables zero, rise filters ones, fall zero.
// - Status byte bit 7 set when any enabled operation event is set.
// - Questionable bit 10 summarises enabled sequence events.
// - Questionable bit 5 summarises enabled frequency events.
`include "ser_consts.vh"

module ser_status_top #(
	parameter W = 16,
	parameter NGRP = 6
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Channel condition sources, bit 0 is channel 1
	input wire [1:0] outputOffCh,
	input wire [1:0] ampClippedCh,
	input wire [1:0] signalInvalidCh,
	input wire [1:0] seqDataErrCh,
	input wire [1:0] playtimeErrCh,
	input wire [1:0] streamUnderrunCh,
	input wire [1:0] runningCh,
	// Global status commands, one-cycle pulses
	input wire clearStatusCmd,
	input wire statusPresetCmd,
	// Register command port
	input wire cmdValid,
	input wire cmdWrite,
	input wire [2:0] cmdGroup,
	input wire [2:0] cmdReg,
	input wire [W-1:0] cmdData,
	// Register read answer
	output wire cmdReady,
	output reg rspValid_r,
	output reg [W-1:0] rspData_r,
	// Summaries toward the status byte
	output reg operationSummary_r,
	output reg questionableSummary_r
);
	// Implemented bits of each group
	function [W-1:0] grpMask;
		input integer g;
		begin
			case (g)
				0: grpMask = `SER_MASK_QUES;
				1: grpMask = `SER_MASK_OPER;
				2: grpMask = `SER_MASK_VOLT;
				3: grpMask = `SER_MASK_FREQ;
				4: grpMask = `SER_MASK_SEQ;
				5: grpMask = `SER_MASK_RUN;
				default: grpMask = {W{1'b0}};
			endcase
		end
	endfunction

	// Flattened per-group registers, group g at bits [g*W +: W]
	wire [NGRP*W-1:0] condFlat;
	wire [NGRP*W-1:0] eventFlat;
	wire [NGRP*W-1:0] enableFlat;
	wire [NGRP*W-1:0] riseFlat;
	wire [NGRP*W-1:0] fallFlat;
	wire [NGRP-1:0] summary;
	wire [NGRP-1:0] wrEnable;
	wire [NGRP-1:0] wrRise;
	wire [NGRP-1:0] wrFall;
	wire [NGRP-1:0] rdEvent;
	wire [W-1:0] quesCond;
	wire [W-1:0] operCond;
	wire [W-1:0] voltCond;
	wire [W-1:0] freqCond;
	wire [W-1:0] seqCond;
	wire [W-1:0] runCond;
	reg [W-1:0] rdMux;
	reg [W-1:0] rdSel;
	integer k;

	// Every command is taken in the cycle it is offered
	assign cmdReady = 1'b1;

	ser_cmd_decode #(
		.NGRP(NGRP)
	) ser_cmd_decode_inst (
		.cmdValid(cmdValid),
		.cmdWrite(cmdWrite),
		.cmdGroup(cmdGroup),
		.cmdReg(cmdReg),
		.wrEnable(wrEnable),
		.wrRise(wrRise),
		.wrFall(wrFall),
		.rdEvent(rdEvent)
	);

	// Channel sources into the leaf groups
	assign voltCond = {{(W-4){1'b0}}, ampClippedCh, outputOffCh};
	assign freqCond = {{(W-2){1'b0}}, signalInvalidCh};
	assign seqCond = {{(W-6){1'b0}}, streamUnderrunCh, playtimeErrCh, seqDataErrCh};
	assign runCond = {{(W-2){1'b0}}, runningCh};

	// Leaf summaries become conditions of the parent groups
	// Summary bits are widened before the shift so no bit is dropped or padded silently
	assign operCond = {{(W-1){1'b0}}, summary[`SER_GRP_RUN]} << `SER_OPER_RUN_BIT;
	assign quesCond = ({{(W-1){1'b0}}, summary[`SER_GRP_VOLT]} << `SER_QUES_VOLT_BIT)
		| ({{(W-1){1'b0}}, summary[`SER_GRP_FREQ]} << `SER_QUES_FREQ_BIT)
		| ({{(W-1){1'b0}}, summary[`SER_GRP_SEQ]} << `SER_QUES_SEQ_BIT);

	assign condFlat = {runCond, seqCond, freqCond, voltCond, operCond, quesCond};

	genvar g;
	generate
		for (g = 0; g < NGRP; g = g + 1) begin : grp
			localparam [W-1:0] MASK = grpMask(g);
			reg [W-1:0] event_r;
			reg [W-1:0] enable_r;
			reg [W-1:0] rise_r;
			reg [W-1:0] fall_r;
			wire [W-1:0] cond;
			wire [W-1:0] hit;

			assign cond = condFlat[g*W +: W] & MASK;

			ser_edge_filter #(
				.WIDTH(W)
			) ser_edge_filter_inst (
				.clk_sys(clk_sys),
				.reset(reset),
				.cond(cond),
				.riseFilter(rise_r),
				.fallFilter(fall_r),
				.hit(hit)
			);

			// New edges win over clear-status or an event read in the same cycle; preset and reset still drop them
			always @(posedge clk_sys) begin
				if (reset || statusPresetCmd) begin
					event_r <= `SER_EVENT_CLEAR;
				end else if (clearStatusCmd || rdEvent[g]) begin
					event_r <= hit & MASK;
				end else begin
					event_r <= (event_r | hit) & MASK;
				end
			end

			// Clear-status does not touch enables or filters
			always @(posedge clk_sys) begin
				if (reset || statusPresetCmd) begin
					enable_r <= `SER_ENABLE_PRESET & MASK;
					rise_r <= `SER_RISE_PRESET & MASK;
					fall_r <= `SER_FALL_PRESET & MASK;
				end else begin
					if (wrEnable[g]) begin
						enable_r <= cmdData & MASK;
					end
					if (wrRise[g]) begin
						rise_r <= cmdData & MASK;
					end
					if (wrFall[g]) begin
						fall_r <= cmdData & MASK;
					end
				end
			end

			assign summary[g] = |(event_r & enable_r);
			assign eventFlat[g*W +: W] = event_r;
			assign enableFlat[g*W +: W] = enable_r;
			assign riseFlat[g*W +: W] = rise_r;
			assign fallFlat[g*W +: W] = fall_r;
		end
	endgenerate

	// Read select: whole word as one weighted value; unknown codes read zero
	always @* begin
		rdSel = {W{1'b0}};
		for (k = 0; k < NGRP; k = k + 1) begin
			if (cmdGroup == k[2:0]) begin
				case (cmdReg)
					`SER_REG_EVENT: rdSel = eventFlat[k*W +: W];
					`SER_REG_COND: rdSel = condFlat[k*W +: W] & grpMask(k);
					`SER_REG_ENABLE: rdSel = enableFlat[k*W +: W];
					`SER_REG_FALL: rdSel = fallFlat[k*W +: W];
					`SER_REG_RISE: rdSel = riseFlat[k*W +: W];
					default: rdSel = {W{1'b0}};
				endcase
			end
		end
		rdMux = rdSel;
	end

	// Answer to a read one cycle later; writes get no answer
	always @(posedge clk_sys) begin
		if (reset) begin
			rspValid_r <= 1'b0;
			rspData_r <= {W{1'b0}};
		end else begin
			rspValid_r <= cmdValid & ~cmdWrite;
			if (cmdValid && !cmdWrite) begin
				rspData_r <= rdMux;
			end
		end
	end

	// Summaries registered toward the status byte
	always @(posedge clk_sys) begin
		if (reset) begin
			operationSummary_r <= 1'b0;
			questionableSummary_r <= 1'b0;
		end else begin
			operationSummary_r <= summary[`SER_GRP_OPER];
			questionableSummary_r <= summary[`SER_GRP_QUES];
		end
	end
endmodule // ser_status_top

/* File: tb/ser_status_properties.sv */
// Concurrent checks on the status event reporting ports
module ser_status_properties (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Command port
	input wire cmdValid,
	input wire cmdWrite,
	input wire [2:0] cmdGroup,
	input wire [2:0] cmdReg,
	input wire cmdReady,
	input wire rspValid_r,
	input wire [15:0] rspData_r,
	// Sources and summaries
	input wire [1:0] outputOffCh,
	input wire [1:0] ampClippedCh,
	input wire [1:0] runningCh,
	input wire statusPresetCmd,
	input wire operationSummary_r,
	input wire questionableSummary_r
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire rd = cmdValid && !cmdWrite;
	ready_always_a: assert property (cmdReady)
		else $error("cmdReady low");
	read_answer_a: assert property (rd |=> rspValid_r)
		else $error("no read answer");
	no_stray_a: assert property (!rd |=> !rspValid_r)
		else $error("answer without read");
	data_hold_a: assert property (!rd |=> $stable(rspData_r))
		else $error("read data moved");
	volt_cond_a: assert property (rd && cmdGroup == 3'h2 && cmdReg == 3'h1
		|=> rspData_r == {12'h000, $past(ampClippedCh), $past(outputOffCh)})
		else $error("bad voltage condition");
	run_cond_a: assert property (rd && cmdGroup == 3'h5 && cmdReg == 3'h1
		|=> rspData_r == {14'h0000, $past(runningCh)})
		else $error("bad run condition");
	unmapped_zero_a: assert property (rd && cmdGroup[2:1] == 2'h3
		|=> rspData_r == 16'h0000)
		else $error("unmapped read not zero");
	preset_quiet_a: assert property (statusPresetCmd ##1 !(cmdValid && cmdWrite)
		|=> !operationSummary_r && !questionableSummary_r)
		else $error("summary after preset");
endmodule // ser_status_properties

bind ser_status_top ser_status_properties ser_status_properties_inst (.*);

/* File: tb/ser_status_top_tb.sv */
// Self-checking bench for the status event reporting block
module ser_status_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, reset = 1, clearStatusCmd = 0, statusPresetCmd = 0;
	logic cmdValid = 0, cmdWrite = 0;
	logic [1:0] outputOffCh = 0, ampClippedCh = 0, signalInvalidCh = 0, seqDataErrCh = 0;
	logic [1:0] playtimeErrCh = 0, streamUnderrunCh = 0, runningCh = 0;
	logic [2:0] cmdGroup = 0, cmdReg = 0, g, r;
	logic [15:0] cmdData = 0, d, v;
	logic [31:0] seed = 32'h8CD6;
	wire cmdReady, rspValid_r, operationSummary_r, questionableSummary_r;
	wire [15:0] rspData_r;
	int nMismatch = 0, checked = 0;
	always #2.5 clk_sys = ~clk_sys;
	ser_status_top ser_status_top_inst (.*);
	function automatic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic [15:0] msk(input [2:0] k);
		case (k)
			3'h0: return 16'h0421;
			3'h1: return 16'h0100;
			3'h2: return 16'h000F;
			3'h4: return 16'h003F;
			3'h6, 3'h7: return 16'h0000;
			default: return 16'h0003;
		endcase
	endfunction
	function automatic [15:0] cnd(input [2:0] k);
		case (k)
			3'h2: return {12'h000, ampClippedCh, outputOffCh};
			3'h3: return {14'h0000, signalInvalidCh};
			3'h4: return {10'h000, streamUnderrunCh, playtimeErrCh, seqDataErrCh};
			3'h5: return {14'h0000, runningCh};
			default: return 16'h0000;
		endcase
	endfunction
	task automatic chk(input string nm, input [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cmd(input w, input [2:0] k, q, input [15:0] x);
		@(posedge clk_sys);
		cmdValid <= 1;
		cmdWrite <= w;
		cmdGroup <= k;
		cmdReg <= q;
		cmdData <= x;
		@(posedge clk_sys);
		cmdValid <= 0;
		#1 d = rspData_r;
	endtask
	// Bits 13:12 are the run sources, bit 0 is output 1 switched off
	task automatic drv(input [13:0] x);
		@(posedge clk_sys);
		{runningCh, streamUnderrunCh, playtimeErrCh, seqDataErrCh, signalInvalidCh,
			ampClippedCh, outputOffCh} <= x;
	endtask
	// Extra cycles let the child, parent and summary stages settle
	task automatic pls(input p);
		@(posedge clk_sys);
		{statusPresetCmd, clearStatusCmd} <= p ? 2'h2 : 2'h1;
		@(posedge clk_sys);
		{statusPresetCmd, clearStatusCmd} <= 2'h0;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic testDone();
		if (nMismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		nMismatch++;
		testDone();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 0;
		for (int i = 0; i < 7; i++) begin
			cmd(0, i[2:0], 2, 0);
			chk("enable", d, 0);
			cmd(0, i[2:0], 4, 0);
			chk("rise", d, msk(i[2:0]));
			cmd(0, i[2:0], 3, 0);
			chk("fall", d, 0);
		end
		cmd(0, 1, 5, 0);
		chk("unmapped reg", d, 0);
		repeat (30) begin
			g = 3'(rnd() % 6);
			r = 3'(2 + rnd() % 3);
			v = 16'(rnd());
			cmd(1, g, r, v);
			cmd(0, g, r, 0);
			chk("readback", d, v & msk(g));
		end
		repeat (10) begin
			drv(14'(rnd()));
			for (int i = 2; i < 7; i++) begin
				cmd(0, i[2:0], 1, 0);
				chk("cond", d, cnd(i[2:0]));
			end
		end
		for (int f = 0; f < 4; f++) begin
			cmd(1, 5, 4, f[0] ? 16'h0003 : 16'h0000);
			cmd(1, 5, 3, f[1] ? 16'h0003 : 16'h0000);
			drv(0);
			cmd(0, 5, 0, 0);
			drv(14'h1000);
			cmd(0, 5, 0, 0);
			chk("rise event", d, {15'h0000, f[0]});
			drv(0);
			cmd(0, 5, 0, 0);
			chk("fall event", d, {15'h0000, f[1]});
			cmd(1, 5, 0, 16'hFFFF);
			cmd(0, 5, 0, 0);
			chk("event cleared", d, 0);
		end
		pls(1);
		for (int i = 0; i < 6; i++)
			cmd(1, i[2:0], 2, 16'hFFFF);
		drv(14'h1020);
		repeat (4) @(posedge clk_sys);
		cmd(0, 1, 1, 0);
		chk("oper cond", d, 16'h0100);
		cmd(0, 0, 1, 0);
		chk("ques cond", d, 16'h0020);
		chk("oper sum", operationSummary_r, 1);
		chk("ques sum", questionableSummary_r, 1);
		drv(14'h1061);
		repeat (4) @(posedge clk_sys);
		cmd(0, 0, 1, 0);
		chk("ques cond", d, 16'h0421);
		cmd(1, 3, 2, 16'h0001);
		cmd(0, 0, 1, 0);
		chk("ques masked", d, 16'h0401);
		cmd(1, 5, 3, 16'h0002);
		pls(0);
		cmd(0, 0, 1, 0);
		chk("ques cond", d, 0);
		chk("ques sum", questionableSummary_r, 0);
		cmd(0, 1, 2, 0);
		chk("oper enable", d, 16'h0100);
		cmd(0, 5, 4, 0);
		chk("run rise", d, 16'h0003);
		cmd(0, 5, 3, 0);
		chk("run fall", d, 16'h0002);
		pls(1);
		cmd(0, 1, 2, 0);
		chk("oper enable", d, 0);
		cmd(0, 5, 3, 0);
		chk("run fall", d, 0);
		testDone();
	end
endmodule // ser_status_top_tb
